// *** standby_halt_pkg.sv ***
`default_nettype none
package standby_halt_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam real CLK_PERIOD_NS   = 4.0;
  localparam real CE_FILTER_US    = 187.5;
  localparam int  CE_FILTER_CYCLES = int'($ceil(CE_FILTER_US * 1000.0 / CLK_PERIOD_NS));
  localparam int  TIMER_CARRY_FLAG_SHORT_MS   = 5;
  localparam int  TIMER_CARRY_FLAG_LONG_MS    = 100;
  localparam int  TIMER_CARRY_FLAG_SHORT_CYCLES = int'($floor(TIMER_CARRY_FLAG_SHORT_MS * 1000000.0 / CLK_PERIOD_NS));
  localparam int  TIMER_CARRY_FLAG_LONG_CYCLES  = int'($floor(TIMER_CARRY_FLAG_LONG_MS * 1000000.0 / CLK_PERIOD_NS));

  // ----------------------------------------------------------------
  // register map: word indices, byte address is four times the index
  // ----------------------------------------------------------------
  localparam int           ADDR_W        = 8;
  localparam logic [5:0]   REG_CE_IDX    = 6'h07;
  localparam logic [5:0]   REG_TIMER_CARRY_FLAG_IDX  = 6'h17;
  localparam logic [5:0]   REG_CTRL_IDX  = 6'h20;
  localparam logic [5:0]   REG_STAT_IDX  = 6'h21;

  // field positions
  localparam int CE_FLAG_BIT     = 0;
  localparam int TIMER_CARRY_FLAG_FLAG_BIT   = 0;
  localparam int CTRL_TSEL_BIT   = 0;
  localparam int STAT_HALT_BIT   = 0;
  localparam int STAT_STOP_BIT   = 1;
  localparam int STAT_OPND_LSB   = 4;

  // reset values
  localparam logic CTRL_TSEL_RST = 1'b0;

  // halt operand bits
  localparam int HOP_KEY_BIT   = 0;
  localparam int HOP_TIMER_CARRY_FLAG_BIT  = 1;
  localparam int HOP_IRQ_BIT   = 3;

  // interrupt sources, index order is fixed priority (0 highest)
  localparam logic [1:0] IRQ_SRC_REMOTE = 2'h0;
  localparam logic [1:0] IRQ_SRC_TIMER  = 2'h1;
  localparam logic [1:0] IRQ_SRC_VSYNC  = 2'h2;
  localparam logic [1:0] IRQ_SRC_SERIAL = 2'h3;

  // ----------------------------------------------------------------
  // types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_RUN  = 2'b00,
    ST_HALT = 2'b01,
    ST_STOP = 2'b10
  } standby_state_type;

  typedef struct packed {
    logic       halt_valid;
    logic       stop_valid;
    logic [3:0] operand;
  } cpu_cmd_type;

  typedef struct packed {
    logic       valid;
    logic [1:0] source;
  } irq_ack_type;

endpackage : standby_halt_pkg
`default_nettype wire

// *** standby_halt_control.sv ***
// Register access over APB and the register offsets were chosen for this implementation.
`default_nettype none
module standby_halt_control #(
  parameter int unsigned CE_FILTER_CNT  = standby_halt_pkg::CE_FILTER_CYCLES,
  parameter int unsigned TIMER_CARRY_FLAG_SHORT_CNT = standby_halt_pkg::TIMER_CARRY_FLAG_SHORT_CYCLES,
  parameter int unsigned TIMER_CARRY_FLAG_LONG_CNT  = standby_halt_pkg::TIMER_CARRY_FLAG_LONG_CYCLES,
  parameter int          KEY_N          = 4,
  parameter int          IRQ_N          = 4
) (
  input  wire logic                              mclk,
  input  wire logic                              sys_rst,
  // apb slave
  input  wire logic                              psel,
  input  wire logic                              penable,
  input  wire logic                              pwrite,
  input  wire logic [standby_halt_pkg::ADDR_W-1:0] paddr,
  input  wire logic [31:0]                       pwdata,
  output var  logic [31:0]                       prdata,
  output var  logic                              pready,
  output var  logic                              pslverr,
  // pins
  input  wire logic                              chip_enable_pin,
  input  wire logic [KEY_N-1:0]                  key_input_pin,
  input  wire logic [KEY_N-1:0]                  key_adc_select,
  // cpu side
  input  wire standby_halt_pkg::cpu_cmd_type     cpu_cmd,
  input  wire logic                              cpu_irq_window,
  input  wire logic [IRQ_N-1:0]                  irq_request,
  input  wire logic [IRQ_N-1:0]                  irq_permission,
  input  wire logic                              global_irq_enable,
  output var  standby_halt_pkg::irq_ack_type     irq_ack,
  output var  logic                              cpu_stall,
  output var  logic                              resume_next,
  output var  logic                              pc_clear,
  output var  logic                              reg_init,
  output var  logic                              osc_stop,
  output var  logic                              periph_run,
  output var  logic                              device_reset,
  output var  logic                              ce_level,
  output var  logic                              timer_carry_flag
);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [standby_halt_pkg::ADDR_W-1:0] reg_addr(input logic [5:0] idx);
    reg_addr = {idx, 2'b00};
  endfunction : reg_addr

  function automatic standby_halt_pkg::irq_ack_type pick_irq(input logic [IRQ_N-1:0] pend);
    pick_irq = '0;
    for (int i = IRQ_N - 1; i >= 0; i--) begin
      if (pend[i]) begin
        pick_irq.valid  = 1'b1;
        pick_irq.source = 2'(i);
      end
    end
  endfunction : pick_irq

  // ----------------------------------------------------------------
  // pin synchronisers
  // ----------------------------------------------------------------
  logic             ce_meta_q;
  logic             ce_sync_q;
  logic [KEY_N-1:0] key_meta_q;
  logic [KEY_N-1:0] key_sync_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ce_meta_q  <= 1'b0;
      ce_sync_q  <= 1'b0;
      key_meta_q <= '0;
      key_sync_q <= '0;
    end else begin
      ce_meta_q  <= chip_enable_pin;
      ce_sync_q  <= ce_meta_q;
      key_meta_q <= key_input_pin;
      key_sync_q <= key_meta_q;
    end
  end

  // ----------------------------------------------------------------
  // chip-enable noise filter and reset edge
  // ----------------------------------------------------------------
  logic [31:0] ce_cnt_q;
  logic        ce_level_q;
  logic        ce_rise;

  // level changes only after the new value has held a full filter time
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ce_cnt_q   <= '0;
      ce_level_q <= 1'b0;
    end else if (ce_sync_q == ce_level_q) begin
      ce_cnt_q <= '0;
    end else if (ce_cnt_q >= CE_FILTER_CNT - 1) begin
      ce_cnt_q   <= '0;
      ce_level_q <= ce_sync_q;
    end else begin
      ce_cnt_q <= ce_cnt_q + 32'h00000001;
    end
  end

  assign ce_rise = (ce_cnt_q >= CE_FILTER_CNT - 1) && ce_sync_q && !ce_level_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      device_reset <= 1'b1;
    end else begin
      device_reset <= ce_rise;
    end
  end

  // ----------------------------------------------------------------
  // key input latches
  // ----------------------------------------------------------------
  logic [KEY_N-1:0] key_latch_q;

  // a pin handed to the converter keeps its last level, so a stored
  // high still counts as a pressed key
  generate
    for (genvar k = 0; k < KEY_N; k++) begin : g_key
      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          key_latch_q[k] <= 1'b0;
        end else if (!key_adc_select[k]) begin
          key_latch_q[k] <= key_sync_q[k];
        end
      end
    end
  endgenerate

  // ----------------------------------------------------------------
  // apb front end
  // ----------------------------------------------------------------
  logic        ctrl_tsel_q;
  logic        apb_setup;
  logic        apb_done;
  logic        wr_ctrl;
  logic        rd_timer_carry_flag;
  logic        timer_carry_flag_read_bit_q;
  logic        addr_hit;
  logic [31:0] rd_word;

  standby_halt_pkg::standby_state_type state_q;
  logic [3:0]  halt_opnd_q;
  logic        timer_carry_flag_q;

  assign apb_setup = psel && !penable && !pready;
  assign apb_done  = psel && penable && pready;
  assign wr_ctrl   = apb_done && pwrite && (paddr == reg_addr(standby_halt_pkg::REG_CTRL_IDX));
  assign rd_timer_carry_flag   = apb_done && !pwrite && (paddr == reg_addr(standby_halt_pkg::REG_TIMER_CARRY_FLAG_IDX));

  always_comb begin
    rd_word  = '0;
    addr_hit = 1'b1;
    unique case (paddr)
      reg_addr(standby_halt_pkg::REG_CE_IDX):
        rd_word[standby_halt_pkg::CE_FLAG_BIT] = ce_level_q;
      reg_addr(standby_halt_pkg::REG_TIMER_CARRY_FLAG_IDX):
        rd_word[standby_halt_pkg::TIMER_CARRY_FLAG_FLAG_BIT] = timer_carry_flag_q;
      reg_addr(standby_halt_pkg::REG_CTRL_IDX):
        rd_word[standby_halt_pkg::CTRL_TSEL_BIT] = ctrl_tsel_q;
      reg_addr(standby_halt_pkg::REG_STAT_IDX): begin
        rd_word[standby_halt_pkg::STAT_HALT_BIT] = (state_q == standby_halt_pkg::ST_HALT);
        rd_word[standby_halt_pkg::STAT_STOP_BIT] = (state_q == standby_halt_pkg::ST_STOP);
        rd_word[standby_halt_pkg::STAT_OPND_LSB +: 4] = halt_opnd_q;
      end
      default:
        addr_hit = 1'b0;
    endcase
  end

  // no wait state: data is captured in the setup cycle, pready rises
  // in the access cycle
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pready          <= 1'b0;
      prdata          <= '0;
      pslverr         <= 1'b0;
      timer_carry_flag_read_bit_q <= 1'b0;
    end else if (apb_setup) begin
      pready          <= 1'b1;
      prdata          <= pwrite ? 32'h00000000 : rd_word;
      pslverr         <= !addr_hit;
      timer_carry_flag_read_bit_q <= timer_carry_flag_q;
    end else begin
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // standby state machine
  // ----------------------------------------------------------------
  logic                          stop_ok;
  logic                          timer_carry_flag_tick;
  logic                          key_release;
  logic                          timer_carry_flag_release;
  logic                          irq_release;
  logic [IRQ_N-1:0]              irq_pending;
  logic                          irq_fire;
  standby_halt_pkg::irq_ack_type irq_pick;

  // the stop operand is not decoded; software is expected to give zero
  assign stop_ok = cpu_cmd.stop_valid && !ce_level_q;

  assign irq_pending = irq_request & irq_permission & {IRQ_N{global_irq_enable}};
  assign irq_pick    = pick_irq(irq_pending);

  // in halt only an enabled interrupt operand lets an acknowledge through
  always_comb begin
    irq_fire = 1'b0;
    unique case (state_q)
      standby_halt_pkg::ST_RUN:
        irq_fire = irq_pick.valid && cpu_irq_window && !cpu_cmd.halt_valid;
      standby_halt_pkg::ST_HALT:
        irq_fire = irq_pick.valid && halt_opnd_q[standby_halt_pkg::HOP_IRQ_BIT];
      standby_halt_pkg::ST_STOP:
        irq_fire = 1'b0;
      default:
        irq_fire = 1'b0;
    endcase
  end

  assign key_release  = halt_opnd_q[standby_halt_pkg::HOP_KEY_BIT] && (|key_latch_q);
  assign timer_carry_flag_release = halt_opnd_q[standby_halt_pkg::HOP_TIMER_CARRY_FLAG_BIT] && (timer_carry_flag_tick || timer_carry_flag_q);
  assign irq_release  = (state_q == standby_halt_pkg::ST_HALT) && irq_fire;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      state_q     <= standby_halt_pkg::ST_RUN;
      halt_opnd_q <= 4'h0;
    end else if (ce_rise) begin
      state_q     <= standby_halt_pkg::ST_RUN;
      halt_opnd_q <= 4'h0;
    end else begin
      unique case (state_q)
        standby_halt_pkg::ST_RUN: begin
          if (stop_ok) begin
            state_q <= standby_halt_pkg::ST_STOP;
          end else if (cpu_cmd.halt_valid) begin
            state_q     <= standby_halt_pkg::ST_HALT;
            halt_opnd_q <= cpu_cmd.operand;
          end
        end
        standby_halt_pkg::ST_HALT: begin
          // zero operand: nothing below fires, only a reset leaves
          if (key_release || timer_carry_flag_release || irq_release) begin
            state_q     <= standby_halt_pkg::ST_RUN;
            halt_opnd_q <= 4'h0;
          end
        end
        standby_halt_pkg::ST_STOP: begin
          state_q <= standby_halt_pkg::ST_STOP;
        end
        default: begin
          state_q <= standby_halt_pkg::ST_RUN;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // cpu facing outputs
  // ----------------------------------------------------------------
  logic halt_leaving;

  assign halt_leaving = (state_q == standby_halt_pkg::ST_HALT) && !ce_rise &&
                        (key_release || timer_carry_flag_release || irq_release);

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      cpu_stall   <= 1'b0;
      resume_next <= 1'b0;
      irq_ack     <= '0;
    end else begin
      cpu_stall   <= (state_q != standby_halt_pkg::ST_RUN && !ce_rise && !halt_leaving) ||
                     (state_q == standby_halt_pkg::ST_RUN && !ce_rise &&
                      (stop_ok || cpu_cmd.halt_valid));
      // plain release continues after the pause; an interrupt release
      // goes to the vector and returns there through the return instruction
      resume_next <= halt_leaving && !irq_release;
      irq_ack.valid  <= irq_fire && !ce_rise;
      irq_ack.source <= irq_fire ? irq_pick.source : 2'h0;
    end
  end

  // ----------------------------------------------------------------
  // oscillator stop and register initialisation
  // ----------------------------------------------------------------
  logic stop_entry;

  assign stop_entry = (state_q == standby_halt_pkg::ST_RUN) && stop_ok && !ce_rise;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      pc_clear   <= 1'b0;
      reg_init   <= 1'b0;
      osc_stop   <= 1'b0;
      periph_run <= 1'b1;
    end else begin
      pc_clear   <= stop_entry;
      reg_init   <= stop_entry;
      osc_stop   <= ce_rise ? 1'b0 : (osc_stop || stop_entry);
      // halt leaves peripherals running, only stop halts them
      periph_run <= ce_rise || !(osc_stop || stop_entry);
    end
  end

  // ----------------------------------------------------------------
  // control register
  // ----------------------------------------------------------------
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ctrl_tsel_q <= standby_halt_pkg::CTRL_TSEL_RST;
    end else if (ce_rise || stop_entry) begin
      ctrl_tsel_q <= standby_halt_pkg::CTRL_TSEL_RST;
    end else if (wr_ctrl) begin
      ctrl_tsel_q <= pwdata[standby_halt_pkg::CTRL_TSEL_BIT];
    end
  end

  // ----------------------------------------------------------------
  // timer carry
  // ----------------------------------------------------------------
  logic [31:0] timer_carry_flag_cnt_q;
  logic [31:0] timer_carry_flag_limit;

  assign timer_carry_flag_limit = ctrl_tsel_q ? 32'(TIMER_CARRY_FLAG_LONG_CNT - 1) : 32'(TIMER_CARRY_FLAG_SHORT_CNT - 1);
  assign timer_carry_flag_tick  = periph_run && (timer_carry_flag_cnt_q >= timer_carry_flag_limit);

  // prescaler keeps running while halted, clears on stop entry and holds at zero in stop
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_carry_flag_cnt_q <= '0;
    end else if (ce_rise || stop_entry || timer_carry_flag_tick) begin
      timer_carry_flag_cnt_q <= '0;
    end else if (periph_run) begin
      timer_carry_flag_cnt_q <= timer_carry_flag_cnt_q + 32'h00000001;
    end
  end

  // a read clears only the value it returned; a new set wins
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_carry_flag_q <= 1'b0;
    end else if (ce_rise || stop_entry) begin
      timer_carry_flag_q <= 1'b0;
    end else begin
      timer_carry_flag_q <= timer_carry_flag_tick || (timer_carry_flag_q && !(rd_timer_carry_flag && timer_carry_flag_read_bit_q));
    end
  end

  // ----------------------------------------------------------------
  // flag outputs
  // ----------------------------------------------------------------
  // filter flop drives the flag itself, so flag and reset pulse line up
  assign ce_level = ce_level_q;

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      timer_carry_flag <= 1'b0;
    end else begin
      timer_carry_flag <= timer_carry_flag_q;
    end
  end

endmodule : standby_halt_control
`default_nettype wire

// *** standby_halt_assertions.sv ***
`default_nettype none
module standby_halt_assertions #(
  parameter int unsigned CE_FILTER_CNT = 8
) (
  input wire logic                          mclk,
  input wire logic                          sys_rst,
  input wire logic                          chip_enable_pin,
  input wire logic [3:0]                    key_input_pin,
  input wire logic [3:0]                    key_adc_select,
  input wire standby_halt_pkg::cpu_cmd_type cpu_cmd,
  input wire logic [3:0]                    irq_request,
  input wire logic [3:0]                    irq_permission,
  input wire logic                          global_irq_enable,
  input wire standby_halt_pkg::irq_ack_type irq_ack,
  input wire logic                          cpu_stall,
  input wire logic                          resume_next,
  input wire logic                          pc_clear,
  input wire logic                          reg_init,
  input wire logic                          osc_stop,
  input wire logic                          periph_run,
  input wire logic                          device_reset,
  input wire logic                          ce_level,
  input wire logic                          timer_carry_flag
);
  // ----------------------------------------
  // helpers: pin stability count, held operand
  // ----------------------------------------
  logic        ce_q;
  logic [15:0] ce_cnt_q;
  logic [3:0]  hop_q;
  logic        pend;
  logic        pend0;
  assign pend  = global_irq_enable && |(irq_request & irq_permission);
  assign pend0 = global_irq_enable && irq_request[0] && irq_permission[0];
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      ce_q     <= 1'b0;
      ce_cnt_q <= 16'h0000;
    end else begin
      ce_q     <= chip_enable_pin;
      // saturates so long quiet spans never wrap
      ce_cnt_q <= (chip_enable_pin != ce_q) ? 16'h0000 : ce_cnt_q + 16'(!(&ce_cnt_q));
    end
  end
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      hop_q <= 4'h0;
    end else if (cpu_cmd.halt_valid && !cpu_cmd.stop_valid && !cpu_stall) begin
      hop_q <= cpu_cmd.operand;
    end
  end
  default clocking cb @(posedge mclk); endclocking
  default disable iff (sys_rst);
  stop_nop_a: assert property (cpu_cmd.stop_valid && !cpu_stall && ce_level |=> !osc_stop)
    else $error("stop taken with enable high");
  stop_go_a: assert property (cpu_cmd.stop_valid && !cpu_stall && !ce_level && !device_reset
    |=> osc_stop && pc_clear && reg_init && !periph_run) else $error("stop entry wrong");
  ce_reset_a: assert property ($rose(ce_level) |-> ##[0:1] device_reset)
    else $error("no reset on enable rise");
  ce_filter_a: assert property ($changed(ce_level) |-> ce_cnt_q >= CE_FILTER_CNT)
    else $error("enable level taken too early");
  stall_entry_a: assert property (cpu_cmd.halt_valid && !cpu_stall |=> cpu_stall)
    else $error("halt not entered");
  stall_exit_a: assert property ($fell(cpu_stall) |-> resume_next || irq_ack.valid || device_reset
    || $past(device_reset)) else $error("stall left without cause");
  key_rel_a: assert property ((cpu_stall && !osc_stop && hop_q[0] && |key_input_pin
    && key_adc_select == 4'h0) [*3] |-> ##[0:4] !cpu_stall) else $error("key release missed");
  carry_rel_a: assert property (cpu_stall && !osc_stop && hop_q[1] && timer_carry_flag
    |-> ##[0:1] !cpu_stall) else $error("carry release missed");
  irq_gate_a: assert property (irq_ack.valid |-> $past(pend))
    else $error("ack without enabled request");
  irq_prio_a: assert property (irq_ack.valid && $past(pend0) |-> irq_ack.source == 2'h0)
    else $error("remote source not first");
  halt_noirq_a: assert property (cpu_stall && !hop_q[3] |=> !irq_ack.valid)
    else $error("ack while not selected");
  periph_a: assert property (periph_run == !osc_stop)
    else $error("peripherals halted outside stop");
endmodule : standby_halt_assertions
bind standby_halt_control standby_halt_assertions #(.CE_FILTER_CNT(CE_FILTER_CNT)) chk_i (
  .mclk(mclk), .sys_rst(sys_rst), .chip_enable_pin(chip_enable_pin), .key_input_pin(key_input_pin),
  .key_adc_select(key_adc_select), .cpu_cmd(cpu_cmd), .irq_request(irq_request),
  .irq_permission(irq_permission), .global_irq_enable(global_irq_enable), .irq_ack(irq_ack),
  .cpu_stall(cpu_stall), .resume_next(resume_next), .pc_clear(pc_clear), .reg_init(reg_init),
  .osc_stop(osc_stop), .periph_run(periph_run), .device_reset(device_reset), .ce_level(ce_level),
  .timer_carry_flag(timer_carry_flag));
`default_nettype wire

// *** ext_side_model.sv ***
`default_nettype none
module ext_side_model (
  input  wire logic       mclk,
  input  wire logic       ce_set,
  input  wire logic [3:0] key_set,
  output var  logic       chip_enable_pin,
  output var  logic [3:0] key_input_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // key lines idle low: internal pull-downs, released keys read 0
  always_ff @(posedge mclk) begin
    chip_enable_pin <= ce_set;
    key_input_pin   <= key_set;
  end
endmodule : ext_side_model
`default_nettype wire

// *** tb_standby_halt_control.sv ***
`default_nettype none
module tb_standby_halt_control;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ce_set = 1'b0, gie = 1'b0, seen_rst = 1'b0;
  logic win = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, ce_pin, osc_stop, cpu_stall, resume_next, pc_clear, reg_init, err;
  logic periph_run, device_reset, ce_level, tcf;
  logic [3:0] key_set = 4'h0, key_pin, adc_sel = 4'h0, req = 4'h0, perm = 4'h0;
  standby_halt_pkg::cpu_cmd_type cmd = '0;
  standby_halt_pkg::irq_ack_type ack;
  int n_mismatch = 0, tests_run = 0, ctrl_m = 0;
  always #2 mclk = ~mclk;
  always @(posedge mclk) if (device_reset) seen_rst <= 1'b1;
  ext_side_model far (.mclk(mclk), .ce_set(ce_set), .key_set(key_set), .chip_enable_pin(ce_pin),
    .key_input_pin(key_pin));
  standby_halt_control #(.CE_FILTER_CNT(8), .TIMER_CARRY_FLAG_SHORT_CNT(20), .TIMER_CARRY_FLAG_LONG_CNT(50)) uut (
    .mclk(mclk), .sys_rst(sys_rst), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .chip_enable_pin(ce_pin),
    .key_input_pin(key_pin), .key_adc_select(adc_sel), .cpu_cmd(cmd), .cpu_irq_window(win),
    .irq_request(req), .irq_permission(perm), .global_irq_enable(gie), .irq_ack(ack),
    .cpu_stall(cpu_stall), .resume_next(resume_next), .pc_clear(pc_clear), .reg_init(reg_init),
    .osc_stop(osc_stop), .periph_run(periph_run), .device_reset(device_reset), .ce_level(ce_level),
    .timer_carry_flag(tcf));
  // ----------------------------------------
  // tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    do @(posedge mclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic op(input logic h, input logic s, input logic [3:0] o);
    @(posedge mclk);
    cmd <= {h, s, o};
    @(posedge mclk);
    cmd <= '0;
    @(negedge mclk);
  endtask : op
  // bounded wait; the caller judges the outcome
  task automatic free(input int lim);
    for (int i = 0; i < lim && cpu_stall !== 1'b0; i++) @(negedge mclk);
  endtask : free
  task automatic test_done;
    $display("checks %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : test_done
  initial begin
    repeat (3000) @(posedge mclk);
    n_mismatch++;
    $display("Error at %0t: timeout", $time);
    test_done;
  end
  initial begin
    void'($urandom(46));
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    apb(1'b1, 8'h1C, 32'h1);
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h0);
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'(ctrl_m));
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    ce_set <= 1'b1;
    repeat ($urandom_range(5, 1)) @(posedge mclk);
    ce_set <= 1'b0;
    repeat (20) @(negedge mclk);
    chk(32'(ce_level), 32'h0);
    op(1'b1, 1'b0, 4'b0001);
    chk(32'(cpu_stall), 32'h1);
    apb(1'b0, 8'h84, 32'h0);
    chk(rd, 32'h11);
    key_set <= 4'h1 << $urandom_range(3, 0);
    free(10);
    chk(32'({cpu_stall, resume_next}), 32'h1);
    @(posedge mclk);
    adc_sel <= key_set;
    @(posedge mclk);
    key_set <= 4'h0;
    repeat (6) @(negedge mclk);
    op(1'b1, 1'b0, 4'b0001);
    free(4);
    chk(32'(cpu_stall), 32'h0);
    @(posedge mclk);
    adc_sel <= 4'h0;
    apb(1'b1, 8'h80, 32'h1);
    ctrl_m = 1;
    apb(1'b0, 8'h80, 32'h0);
    chk(rd, 32'(ctrl_m));
    apb(1'b0, 8'h5C, 32'h0);
    chk(rd, 32'h1);
    op(1'b1, 1'b0, 4'b0010);
    free(60);
    chk(32'({cpu_stall, resume_next}), 32'h1);
    @(negedge mclk);
    chk(32'(tcf), 32'h1);
    @(posedge mclk);
    req <= 4'b0010;
    perm <= 4'b0001;
    gie <= 1'b1;
    op(1'b1, 1'b0, 4'b1000);
    repeat (10) @(negedge mclk);
    chk(32'(cpu_stall), 32'h1);
    @(posedge mclk);
    req <= 4'b0011;
    perm <= 4'b0011;
    for (int i = 0; i < 10 && ack.valid !== 1'b1; i++) @(negedge mclk);
    chk(32'({ack, cpu_stall, resume_next}), 32'h10);
    @(posedge mclk);
    win <= 1'b1;
    req <= 4'b0110;
    repeat (3) @(negedge mclk);
    chk(32'(ack), 32'h5);
    @(posedge mclk);
    gie <= 1'b0;
    repeat (3) @(negedge mclk);
    chk(32'(ack), 32'h0);
    @(posedge mclk);
    win <= 1'b0;
    req <= 4'h0;
    op(1'b1, 1'b0, 4'b0000);
    repeat (40) @(negedge mclk);
    chk(32'(cpu_stall), 32'h1);
    @(posedge mclk);
    ce_set <= 1'b1;
    seen_rst <= 1'b0;
    free(30);
    repeat (2) @(negedge mclk);
    chk(32'({seen_rst, ce_level, cpu_stall}), 32'h6);
    apb(1'b0, 8'h80, 32'h0);
    ctrl_m = 0;
    chk(rd, 32'(ctrl_m));
    apb(1'b0, 8'h1C, 32'h0);
    chk(rd, 32'h1);
    op(1'b0, 1'b1, 4'b0000);
    chk(32'({osc_stop, cpu_stall}), 32'h0);
    @(posedge mclk);
    ce_set <= 1'b0;
    repeat (20) @(negedge mclk);
    op(1'b0, 1'b1, 4'b0000);
    chk(32'({osc_stop, cpu_stall, pc_clear, reg_init, periph_run}), 32'h1E);
    @(posedge mclk);
    ce_set <= 1'b1;
    for (int i = 0; i < 30 && osc_stop !== 1'b0; i++) @(negedge mclk);
    chk(32'({osc_stop, cpu_stall}), 32'h0);
    test_done;
  end
endmodule : tb_standby_halt_control
`default_nettype wire
